//--- image_setting_command_handler.sv
// Image setting command interpreter with AXI4-Lite register access
// Behaviour
// R1: clamp code 0 tip, 1 porch, 2 tri-level
// R2: colour intensity accepts 1 to 1000
// R3: percent values in tenths of percent
// R4: contrast accepts 0 to 1000
// R5: chroma/luma delay accepts 20 to 50
// R6: colour space code 1 selects SD component
// R7: colour space affects analog inputs only
// R8: primary wheel delay accepts 0 to 1000
// R9: secondary wheel delay accepts 0 to 1000
// R10: factory restore only with key 111
// R11: restore deletes setups and resets settings
// R12: delete one setup, or all unlocked
// R13: controller unlocks all before deleting all
// R14: event delay 1 to 65535 milliseconds
// R15: dark interval in lines, source dependent range; the code uses one DARK_MAX limit for all sources
// R16: one reply per setting, then ack
// R17: source 0 reads all sources in turn
// R18: controller addresses sources 1 to 50
// R19: record carries switch then slot number
// R20: record carries vertical then horizontal frequency
// R21: source data write creates new setup
// R22: preferences download as separate commands
// R23: out of range parameter is ignored
// R24: ack only after action fully completes
//
// Implementation choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
module image_setting_command_handler
  import image_cmd_pkg::*;
#(
  parameter int SETTINGS_PER_SOURCE = 8,
  parameter int MS_CYCLES = CYC_PER_MS,
  parameter logic [15:0] DARK_MAX = 16'h0100
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Input signal kind
  input wire logic analog_input_i,
  // Applied settings
  output settings_t settings_o,
  output logic [2:0] decode_space_o,
  output logic defaults_restored_o,
  output logic baud_reset_o,
  // Replies to the controller
  output reply_t reply_o
);

  typedef struct packed {
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] cmd;
    logic [31:0] arg0;
    logic [31:0] arg1;
    logic go;
    state_t state;
    logic ack_req;
    logic [4:0] op;
    settings_t set;
    logic [49:0] present;
    logic [49:0] locked;
    logic [31:0] record;
    logic [5:0] src;
    logic [3:0] idx;
    logic all_src;
    logic [31:0] cyc;
    logic [15:0] ms;
    logic restored;
    logic baud;
    reply_t reply;
  } st_t;

  st_t s_q;
  st_t s_d;

  logic wr_fire;
  logic [15:0] a0;
  logic [5:0] sidx;
  logic wr_ok;
  logic [31:0] rd_val;
  logic arg_ok;
  logic src_all;
  logic src_ok;

  assign a0 = s_q.arg0[15:0];
  assign sidx = 6'(a0[5:0] - 6'h01);
  assign wr_fire = s_q.aw_got && s_q.w_got && !s_q.bvalid;

  // Source numbers past the last setup are refused, never wrapped
  assign src_all = (a0 == 16'h0000);
  assign src_ok = (a0 >= 16'h0001) && (a0 <= 16'(SOURCE_MAX));

  // Parameter range of the pending command
  always_comb begin
    case (s_q.cmd[4:0])
      OP_CLAMP: arg_ok = a0 <= CLAMP_MAX; // R1 R23
      OP_COLOR: arg_ok = a0 >= COLOR_MIN && a0 <= PCT_MAX; // R2 R3 R23
      OP_CONTRAST: arg_ok = a0 <= PCT_MAX; // R4 R3 R23
      OP_CHROMA: arg_ok = a0 >= CHROMA_MIN && a0 <= CHROMA_MAX; // R5 R23
      OP_SPACE: arg_ok = a0 <= SPACE_MAX; // R6 R23
      OP_WHEEL1: arg_ok = a0 <= PCT_MAX; // R8 R23
      OP_WHEEL2: arg_ok = a0 <= PCT_MAX; // R9 R23
      OP_DARK: arg_ok = a0 <= DARK_MAX; // R15 R23
      OP_DEFAULTS: arg_ok = a0 == DEFAULT_KEY; // R10
      OP_DELAY: arg_ok = a0 >= DELAY_MIN; // R14 R23
      OP_WRITE: arg_ok = src_ok; // R21 R23
      default: arg_ok = src_all || src_ok; // R12 R17 R23
    endcase
  end

  function automatic logic [31:0] strobe(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  always_comb begin
    case (s_q.arg0[7:0])
      CMD_OFF: rd_val = s_q.cmd;
      ARG0_OFF: rd_val = s_q.arg0;
      ARG1_OFF: rd_val = s_q.arg1;
      STATUS_OFF: rd_val = {27'h0, s_q.state};
      default: rd_val = 32'h0;
    endcase
  end

  always_comb begin
    s_d = s_q;
    s_d.restored = 1'b0;
    s_d.baud = 1'b0;
    s_d.reply = '0;
    wr_ok = 1'b1;
    // Write channel capture
    if (s_axi_awvalid && !s_q.aw_got) begin
      s_d.aw_got = 1'b1;
      s_d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_q.w_got) begin
      s_d.w_got = 1'b1;
      s_d.wdata = s_axi_wdata;
      s_d.wstrb = s_axi_wstrb;
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (wr_fire) begin
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = 2'h0;
      case (s_q.awaddr)
        CMD_OFF: begin
          if (s_q.state == ST_IDLE) begin
            s_d.cmd = strobe(s_q.cmd, s_q.wdata, s_q.wstrb);
            s_d.go = 1'b1;
          end
        end
        ARG0_OFF: s_d.arg0 = strobe(s_q.arg0, s_q.wdata, s_q.wstrb);
        ARG1_OFF: s_d.arg1 = strobe(s_q.arg1, s_q.wdata, s_q.wstrb);
        default: wr_ok = 1'b0;
      endcase
      if (!wr_ok) begin
        s_d.bresp = 2'h2;
      end
    end
    // Read channel
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !s_q.rvalid) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = 2'h0;
      case (s_axi_araddr)
        CMD_OFF: s_d.rdata = s_q.cmd;
        ARG0_OFF: s_d.rdata = s_q.arg0;
        ARG1_OFF: s_d.rdata = s_q.arg1;
        STATUS_OFF: s_d.rdata = {27'h0, s_q.state};
        CLAMP_OFF: s_d.rdata = {30'h0, s_q.set.clamp};
        COLOR_OFF: s_d.rdata = {22'h0, s_q.set.color};
        CONTRAST_OFF: s_d.rdata = {22'h0, s_q.set.contrast};
        CHROMA_OFF: s_d.rdata = {26'h0, s_q.set.chroma};
        SPACE_OFF: s_d.rdata = {29'h0, s_q.set.space};
        WHEEL1_OFF: s_d.rdata = {22'h0, s_q.set.wheel1};
        WHEEL2_OFF: s_d.rdata = {22'h0, s_q.set.wheel2};
        DARK_OFF: s_d.rdata = {16'h0, s_q.set.dark};
        SETUP_LO_OFF: s_d.rdata = s_q.present[31:0];
        SETUP_HI_OFF: s_d.rdata = {14'h0, s_q.present[49:32]};
        LOCK_LO_OFF: s_d.rdata = s_q.locked[31:0];
        LOCK_HI_OFF: s_d.rdata = {14'h0, s_q.locked[49:32]};
        REPLY_OFF: s_d.rdata = {19'h0, s_q.reply};
        RECORD_OFF: s_d.rdata = s_q.record;
        default: begin
          s_d.rdata = rd_val & 32'h0;
          s_d.rresp = 2'h2;
        end
      endcase
    end
    // Command sequencer
    case (s_q.state)
      ST_IDLE: begin
        if (s_q.go) begin
          s_d.go = 1'b0;
          s_d.op = s_q.cmd[4:0];
          s_d.ack_req = s_q.cmd[CMD_ACK_BIT];
          s_d.state = s_q.cmd[CMD_ACK_BIT] ? ST_ACK : ST_IDLE;
          case (s_q.cmd[4:0])
            OP_CLAMP: if (arg_ok) s_d.set.clamp = a0[1:0]; // R1 R23
            OP_COLOR: begin
              if (arg_ok) s_d.set.color = a0[9:0]; // R2 R3 R23
            end
            OP_CONTRAST: if (arg_ok) s_d.set.contrast = a0[9:0]; // R4 R3 R23
            OP_CHROMA: begin
              if (arg_ok) s_d.set.chroma = a0[5:0]; // R5 R23
            end
            OP_SPACE: if (arg_ok) s_d.set.space = a0[2:0]; // R6 R23
            OP_WHEEL1: if (arg_ok) s_d.set.wheel1 = a0[9:0]; // R8 R23
            OP_WHEEL2: if (arg_ok) s_d.set.wheel2 = a0[9:0]; // R9 R23
            OP_DARK: if (arg_ok) s_d.set.dark = a0; // R15 R23
            OP_LOCK: begin
              if (src_all) begin
                s_d.locked = {50{s_q.arg1[0]}};
              end else if (src_ok) begin
                s_d.locked[sidx] = s_q.arg1[0];
              end
            end
            OP_DEFAULTS: begin
              if (arg_ok) begin // R10
                s_d.state = ST_CLEAR;
              end
            end
            OP_DELETE: begin
              if (src_all) begin
                s_d.present = s_q.present & s_q.locked; // R12
              end else if (src_ok) begin // R23
                s_d.present[sidx] = 1'b0; // R12
              end
            end
            OP_DELAY: begin
              if (arg_ok) begin // R14 R23
                s_d.ms = a0;
                s_d.cyc = '0;
                s_d.state = ST_WAIT;
              end
            end
            OP_WRITE: begin
              if (arg_ok) begin // R23
                s_d.present[sidx] = 1'b1; // R21
                s_d.record = s_q.arg1; // R19 R20
              end
            end
            OP_READ: begin
              if (arg_ok) begin // R23
                s_d.all_src = (a0[5:0] == 6'h00); // R17
                s_d.src = (a0[5:0] == 6'h00) ? 6'h01 : a0[5:0];
                s_d.idx = '0;
                s_d.state = ST_REPLY;
              end
            end
            default: s_d.state = s_q.cmd[CMD_ACK_BIT] ? ST_ACK : ST_IDLE;
          endcase
        end
      end
      ST_CLEAR: begin
        s_d.present = '0; // R11
        s_d.locked = '0;
        s_d.set = {CLAMP_RST, PCT_RST, PCT_RST, CHROMA_RST, SPACE_RST, WHEEL_RST,
                   WHEEL_RST, DARK_RST};
        s_d.restored = 1'b1;
        s_d.baud = 1'b1;
        s_d.state = s_q.ack_req ? ST_ACK : ST_IDLE; // R24
      end
      ST_WAIT: begin
        if (s_q.cyc == 32'(MS_CYCLES - 1)) begin
          s_d.cyc = '0;
          s_d.ms = 16'(s_q.ms - 16'h0001); // R14
          if (s_q.ms == 16'h0001) begin
            s_d.state = s_q.ack_req ? ST_ACK : ST_IDLE; // R24
          end
        end else begin
          s_d.cyc = 32'(s_q.cyc + 32'h1);
        end
      end
      ST_REPLY: begin
        if (!s_q.present[6'(s_q.src - 6'h01)]) begin
          s_d.idx = '0;
          if (!s_q.all_src || s_q.src == SOURCE_MAX) begin
            s_d.state = s_q.ack_req ? ST_ACK : ST_IDLE;
          end else begin
            s_d.src = 6'(s_q.src + 6'h01); // R17
          end
        end else begin
          s_d.reply.valid = 1'b1; // R16
          s_d.reply.kind = (s_q.idx == 4'h0) ? RPL_RECORD : RPL_SETTING;
          s_d.reply.source = s_q.src;
          s_d.reply.index = s_q.idx;
          if (s_q.idx == 4'(SETTINGS_PER_SOURCE - 1)) begin
            s_d.idx = '0;
            if (!s_q.all_src || s_q.src == SOURCE_MAX) begin
              s_d.state = s_q.ack_req ? ST_ACK : ST_IDLE; // R16 R17
            end else begin
              s_d.src = 6'(s_q.src + 6'h01);
            end
          end else begin
            s_d.idx = 4'(s_q.idx + 4'h1);
          end
        end
      end
      ST_ACK: begin
        s_d.reply.valid = 1'b1; // R24
        s_d.reply.kind = RPL_ACK;
        s_d.reply.source = s_q.src;
        s_d.reply.index = '0;
        s_d.ack_req = 1'b0;
        s_d.state = ST_IDLE;
      end
      default: s_d.state = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      s_q <= '0;
      s_q.state <= ST_IDLE;
      s_q.set <= {CLAMP_RST, PCT_RST, PCT_RST, CHROMA_RST, SPACE_RST, WHEEL_RST,
                  WHEEL_RST, DARK_RST};
    end else begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready = !s_q.aw_got;
  assign s_axi_wready = !s_q.w_got;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = !s_q.rvalid;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign settings_o = s_q.set;
  assign decode_space_o = analog_input_i ? s_q.set.space : SPACE_RST; // R7 R6
  assign defaults_restored_o = s_q.restored;
  assign baud_reset_o = s_q.baud;
  assign reply_o = s_q.reply;

endmodule

//--- image_cmd_pkg.sv
// Package with constants, types and register map for the image setting command handler
package image_cmd_pkg;

  // Register byte offsets
  localparam logic [7:0] CMD_OFF = 8'h00;
  localparam logic [7:0] ARG0_OFF = 8'h04;
  localparam logic [7:0] ARG1_OFF = 8'h08;
  localparam logic [7:0] STATUS_OFF = 8'h0C;
  localparam logic [7:0] CLAMP_OFF = 8'h10;
  localparam logic [7:0] COLOR_OFF = 8'h14;
  localparam logic [7:0] CONTRAST_OFF = 8'h18;
  localparam logic [7:0] CHROMA_OFF = 8'h1C;
  localparam logic [7:0] SPACE_OFF = 8'h20;
  localparam logic [7:0] WHEEL1_OFF = 8'h24;
  localparam logic [7:0] WHEEL2_OFF = 8'h28;
  localparam logic [7:0] DARK_OFF = 8'h2C;
  localparam logic [7:0] SETUP_LO_OFF = 8'h30;
  localparam logic [7:0] SETUP_HI_OFF = 8'h34;
  localparam logic [7:0] LOCK_LO_OFF = 8'h38;
  localparam logic [7:0] LOCK_HI_OFF = 8'h3C;
  localparam logic [7:0] REPLY_OFF = 8'h40;
  localparam logic [7:0] RECORD_OFF = 8'h44;

  // Command codes written to the command register
  localparam logic [4:0] OP_CLAMP = 5'h01;
  localparam logic [4:0] OP_COLOR = 5'h02;
  localparam logic [4:0] OP_CONTRAST = 5'h03;
  localparam logic [4:0] OP_CHROMA = 5'h04;
  localparam logic [4:0] OP_SPACE = 5'h05;
  localparam logic [4:0] OP_WHEEL1 = 5'h06;
  localparam logic [4:0] OP_WHEEL2 = 5'h07;
  localparam logic [4:0] OP_DEFAULTS = 5'h08;
  localparam logic [4:0] OP_DELETE = 5'h09;
  localparam logic [4:0] OP_DELAY = 5'h0A;
  localparam logic [4:0] OP_DARK = 5'h0B;
  localparam logic [4:0] OP_READ = 5'h0C;
  localparam logic [4:0] OP_WRITE = 5'h0D;
  localparam logic [4:0] OP_LOCK = 5'h0E;

  // Command register fields
  localparam int CMD_ACK_BIT = 8;

  // Parameter limits
  localparam logic [15:0] CLAMP_MAX = 16'h0002;
  localparam logic [15:0] COLOR_MIN = 16'h0001;
  localparam logic [15:0] PCT_MAX = 16'h03E8;
  localparam logic [15:0] CHROMA_MIN = 16'h0014;
  localparam logic [15:0] CHROMA_MAX = 16'h0032;
  localparam logic [15:0] SPACE_MAX = 16'h0004;
  localparam logic [15:0] SD_COMPONENT_SPACE = 16'h0001;
  localparam logic [15:0] DEFAULT_KEY = 16'h006F;
  localparam logic [15:0] DELAY_MIN = 16'h0001;
  localparam logic [5:0] SOURCE_MAX = 6'h32;

  // Reset and factory values
  localparam logic [1:0] CLAMP_RST = 2'h1;
  localparam logic [9:0] PCT_RST = 10'h1F4;
  localparam logic [5:0] CHROMA_RST = 6'h20;
  localparam logic [2:0] SPACE_RST = 3'h0;
  localparam logic [9:0] WHEEL_RST = 10'h000;
  localparam logic [15:0] DARK_RST = 16'h0000;

  // Timing
  localparam int CLK_HZ = 20000000;
  localparam int MS_PER_S = 1000;
  localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;

  // Reply kinds reported with each emitted reply
  localparam logic [1:0] RPL_RECORD = 2'h1;
  localparam logic [1:0] RPL_SETTING = 2'h2;
  localparam logic [1:0] RPL_ACK = 2'h3;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_CLEAR = 5'b00010,
    ST_WAIT = 5'b00100,
    ST_REPLY = 5'b01000,
    ST_ACK = 5'b10000
  } state_t;

  // Image settings of the current signal
  typedef struct packed {
    logic [1:0] clamp;
    logic [9:0] color;
    logic [9:0] contrast;
    logic [5:0] chroma;
    logic [2:0] space;
    logic [9:0] wheel1;
    logic [9:0] wheel2;
    logic [15:0] dark;
  } settings_t;

  // One reply to the controller
  typedef struct packed {
    logic valid;
    logic [1:0] kind;
    logic [5:0] source;
    logic [3:0] index;
  } reply_t;

endpackage

//--- image_cmd_chk.sv
// Checker of the command handler port behaviour
`timescale 1ns/1ps
module image_cmd_chk
  import image_cmd_pkg::*;
#(
  parameter int SETTINGS_PER_SOURCE = 8
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // Watched signals
  input wire logic analog_input_i,
  input wire settings_t settings_o,
  input wire logic [2:0] decode_space_o,
  input wire logic defaults_restored_o,
  input wire logic baud_reset_o,
  input wire reply_t reply_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  property p_clamp_code; settings_o.clamp <= 2'h2; endproperty
  a_clamp_code: assert property (p_clamp_code) else $error("clamp code bad");
  property p_color_range; settings_o.color >= 10'h001 && settings_o.color <= 10'h3E8; endproperty
  a_color_range: assert property (p_color_range) else $error("color bad");
  property p_contrast_range; settings_o.contrast <= 10'h3E8; endproperty
  a_contrast_range: assert property (p_contrast_range) else $error("contrast bad");
  property p_chroma_range; settings_o.chroma >= 6'h14 && settings_o.chroma <= 6'h32; endproperty
  a_chroma_range: assert property (p_chroma_range) else $error("chroma bad");
  property p_space_analog; analog_input_i |-> decode_space_o == settings_o.space; endproperty
  a_space_analog: assert property (p_space_analog) else $error("space not applied");
  property p_space_digital; !analog_input_i |-> decode_space_o == 3'h0; endproperty
  a_space_digital: assert property (p_space_digital) else $error("space on digital");
  property p_wheel_range; settings_o.wheel1 <= 10'h3E8 && settings_o.wheel2 <= 10'h3E8; endproperty
  a_wheel_range: assert property (p_wheel_range) else $error("wheel delay bad");
  property p_restore; defaults_restored_o |-> baud_reset_o && settings_o.clamp == CLAMP_RST &&
    settings_o.contrast == PCT_RST && settings_o.dark == DARK_RST; endproperty
  a_restore: assert property (p_restore) else $error("restore incomplete");
  property p_record_first; reply_o.valid && reply_o.kind == RPL_RECORD |-> reply_o.index == 4'h0
    ##1 (reply_o.valid && reply_o.kind == RPL_SETTING && reply_o.index == 4'h1); endproperty
  a_record_first: assert property (p_record_first) else $error("record sequence bad");
  property p_setting_index; reply_o.valid && reply_o.kind == RPL_SETTING |->
    reply_o.index < 4'(SETTINGS_PER_SOURCE); endproperty
  a_setting_index: assert property (p_setting_index) else $error("setting index bad");
  property p_source_num; reply_o.valid && reply_o.kind != RPL_ACK |->
    reply_o.source >= 6'h01 && reply_o.source <= SOURCE_MAX; endproperty
  a_source_num: assert property (p_source_num) else $error("reply source bad");
endmodule

//--- reply_sink.sv
// Controller side model that receives and tallies replies
`timescale 1ns/1ps
module reply_sink
  import image_cmd_pkg::*;
(
  // Clock and replies
  input wire logic mclk_i,
  input wire reply_t reply_i,
  // Tallies
  output int n_rec_o,
  output int n_set_o,
  output int n_ack_o,
  output int cyc_o,
  output int ack_cyc_o,
  output int data_cyc_o
);
  always @(posedge mclk_i) begin
    cyc_o <= cyc_o + 1;
    if (reply_i.valid) begin
      if (reply_i.kind == RPL_ACK) begin
        n_ack_o <= n_ack_o + 1;
        ack_cyc_o <= cyc_o;
      end else begin
        data_cyc_o <= cyc_o;
      end
      if (reply_i.kind == RPL_RECORD) n_rec_o <= n_rec_o + 1;
      if (reply_i.kind == RPL_SETTING) n_set_o <= n_set_o + 1;
    end
  end
endmodule

//--- image_setting_command_handler_tb.sv
// Testbench of the command handler over its register bus
`timescale 1ns/1ps
module image_setting_command_handler_tb
  import image_cmd_pkg::*;
;
  localparam int SPS = 8;
  localparam logic [15:0] DMAX = 16'h0100;
  logic mclk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [7:0] aw_a = 8'h00, ar_a = 8'h00;
  logic aw_v = 1'b0, w_v = 1'b0, ar_v = 1'b0, an = 1'b0;
  logic [31:0] w_d = 32'h0, r_d;
  logic aw_r, w_r, b_v, ar_r, r_v, rst_p, baud_p;
  logic [1:0] b_r, r_r, r;
  logic [2:0] dsp;
  settings_t set;
  reply_t rpl;
  int n_rec, n_set, n_ack, cyc, ack_cyc, data_cyc, n_rst, n_baud, rst_cyc, t0, n;
  int err_count, tests_run;
  logic [79:0] ex[16];
  logic [31:0] d;
  int ops[19] = '{1, 1, 1, 1, 2, 2, 2, 2, 3, 3, 3, 4, 4, 4, 4, 5, 5, 6, 6};
  int vals[19] = '{0, 2, 3, 1, 1000, 0, 1, 1001, 0, 1000, 1001, 20, 19, 50, 51, 1, 5, 1000, 1001};
  image_setting_command_handler #(.SETTINGS_PER_SOURCE(SPS), .MS_CYCLES(4), .DARK_MAX(DMAX))
    image_setting_command_handler_i (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
    .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v), .s_axi_awready(aw_r), .s_axi_wdata(w_d),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(w_v), .s_axi_wready(w_r), .s_axi_bresp(b_r),
    .s_axi_bvalid(b_v), .s_axi_bready(1'b1), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v),
    .s_axi_arready(ar_r), .s_axi_rdata(r_d), .s_axi_rresp(r_r), .s_axi_rvalid(r_v),
    .s_axi_rready(1'b1), .analog_input_i(an), .settings_o(set), .decode_space_o(dsp),
    .defaults_restored_o(rst_p), .baud_reset_o(baud_p), .reply_o(rpl));
  reply_sink reply_sink_i (.mclk_i(mclk_i), .reply_i(rpl), .n_rec_o(n_rec), .n_set_o(n_set),
    .n_ack_o(n_ack), .cyc_o(cyc), .ack_cyc_o(ack_cyc), .data_cyc_o(data_cyc));
  initial forever #25 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    if (rst_p) begin
      n_rst <= n_rst + 1;
      rst_cyc <= cyc;
    end
    if (baud_p) n_baud <= n_baud + 1;
  end
  task automatic complete_run();
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [79:0] seen, input logic [79:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    int k;
    k = 0;
    aw_a <= a;
    w_d <= v;
    aw_v <= 1'b1;
    w_v <= 1'b1;
    do begin
      @(posedge mclk_i);
      k++;
      if (aw_v && aw_r) aw_v <= 1'b0;
      if (w_v && w_r) w_v <= 1'b0;
    end while (b_v !== 1'b1 && k < 50);
    rs = b_r;
    if (b_v !== 1'b1) chk("bvalid", b_v, 1'b1);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    int k;
    k = 0;
    ar_a <= a;
    ar_v <= 1'b1;
    do begin
      @(posedge mclk_i);
      k++;
      if (ar_v && ar_r) ar_v <= 1'b0;
    end while (r_v !== 1'b1 && k < 50);
    v = r_d;
    rs = r_r;
    if (r_v !== 1'b1) chk("rvalid", r_v, 1'b1);
  endtask
  task automatic go(input int op, input logic ack, input logic [31:0] a0, input logic [31:0] a1);
    logic [1:0] rs;
    wr(ARG0_OFF, a0, rs);
    wr(ARG1_OFF, a1, rs);
    wr(CMD_OFF, {23'h0, ack, 3'h0, 5'(op)}, rs);
    t0 = cyc;
    repeat (3) @(posedge mclk_i);
  endtask
  task automatic idle();
    logic [31:0] s;
    logic [1:0] rs;
    int k;
    k = 0;
    do begin
      rd(STATUS_OFF, s, rs);
      k++;
    end while (s !== 32'h1 && k < 5000);
    if (s !== 32'h1) chk("idle", s, 32'h1);
  endtask
  task automatic cmd(input int op, input logic ack, input logic [31:0] a0, input logic [31:0] a1);
    go(op, ack, a0, a1);
    idle();
  endtask
  task automatic rds(input int s, output int nr);
    int br, bs, ba;
    br = n_rec;
    bs = n_set;
    ba = n_ack;
    cmd(OP_READ, 1'b1, s, 0);
    nr = n_rec - br;
    chk("settings", n_set - bs, nr * (SPS - 1));
    chk("ack", n_ack - ba, 1);
    chk("ack last", ack_cyc > data_cyc, 1'b1);
  endtask
  function automatic logic [79:0] fld(input int op);
    case (op)
      1: fld = set.clamp;
      2: fld = set.color;
      3: fld = set.contrast;
      4: fld = set.chroma;
      5: fld = set.space;
      default: fld = set.wheel1;
    endcase
  endfunction
  initial begin
    repeat (16) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    @(posedge mclk_i);
    chk("reset", set, {CLAMP_RST, PCT_RST, PCT_RST, CHROMA_RST, SPACE_RST, WHEEL_RST,
      WHEEL_RST, DARK_RST});
    rd(CONTRAST_OFF, d, r);
    chk("contrast reg", d, {22'h0, PCT_RST});
    wr(8'hF0, 32'h1, r);
    chk("unmapped wr", r, 2'h2);
    wr(CLAMP_OFF, 32'h0, r);
    chk("readonly wr", r, 2'h2);
    rd(8'hF0, d, r);
    chk("unmapped rd", {r, d}, 34'h200000000);
    an <= 1'b1;
    for (int i = 0; i < 19; i++) begin
      cmd(ops[i], 1'b0, vals[i], 0);
      if (vals[i] >= (ops[i] == 2 ? COLOR_MIN : ops[i] == 4 ? CHROMA_MIN : 0) &&
          vals[i] <= (ops[i] == 1 ? CLAMP_MAX : ops[i] == 4 ? CHROMA_MAX :
          ops[i] == 5 ? SPACE_MAX : PCT_MAX)) ex[ops[i]] = vals[i];
      chk("setting", fld(ops[i]), ex[ops[i]]);
    end
    cmd(OP_WHEEL2, 1'b0, 0, 0);
    cmd(OP_WHEEL2, 1'b0, 1001, 0);
    chk("wheel2", set.wheel2, 10'h000);
    cmd(OP_DARK, 1'b0, DMAX, 0);
    cmd(OP_DARK, 1'b0, DMAX + 1, 0);
    chk("dark", set.dark, DMAX);
    chk("analog space", dsp, SD_COMPONENT_SPACE[2:0]);
    an <= 1'b0;
    @(posedge mclk_i);
    chk("digital space", dsp, 3'h0);
    go(OP_DELAY, 1'b1, 5, 0);
    rd(STATUS_OFF, d, r);
    chk("waiting", d, 32'h4);
    wr(ARG0_OFF, 32'h0, r);
    wr(CMD_OFF, {27'h0, OP_CLAMP}, r);
    idle();
    chk("delay span", (ack_cyc - t0 >= 20) && (ack_cyc - t0 <= 26), 1'b1);
    chk("dropped", set.clamp, 2'h1);
    cmd(OP_DELAY, 1'b1, 0, 0);
    chk("no delay", ack_cyc - t0 < 20, 1'b1);
    cmd(OP_WRITE, 1'b0, 5, 32'h0001176C);
    cmd(OP_WRITE, 1'b0, 34, 32'h0001176D);
    rd(RECORD_OFF, d, r);
    chk("record", d, 32'h0001176D);
    rds(0, n);
    chk("all", n, 2);
    rds(5, n);
    chk("one", n, 1);
    cmd(OP_DELETE, 1'b0, 64, 0);
    rds(0, n);
    chk("bad source", n, 2);
    cmd(OP_LOCK, 1'b0, 5, 1);
    cmd(OP_DELETE, 1'b0, 0, 0);
    rds(0, n);
    chk("unlocked gone", n, 1);
    cmd(OP_DELETE, 1'b0, 5, 0);
    rds(0, n);
    chk("locked gone", n, 0);
    cmd(OP_WRITE, 1'b0, 5, 32'h0001176C);
    cmd(OP_WRITE, 1'b0, 34, 32'h0001176D);
    cmd(OP_LOCK, 1'b0, 0, 1);
    cmd(OP_DELETE, 1'b0, 0, 0);
    rds(0, n);
    chk("all locked", n, 2);
    cmd(OP_LOCK, 1'b0, 0, 0);
    cmd(OP_DELETE, 1'b0, 0, 0);
    rds(0, n);
    chk("all gone", n, 0);
    cmd(OP_WRITE, 1'b0, 7, 32'h1);
    cmd(OP_CONTRAST, 1'b0, 7, 0);
    cmd(OP_DEFAULTS, 1'b1, 110, 0);
    chk("bad key", {n_rst, set.contrast}, {32'h0, 10'h007});
    cmd(OP_DEFAULTS, 1'b1, DEFAULT_KEY, 0);
    chk("restore", {n_rst, n_baud, set.contrast}, {32'h1, 32'h1, PCT_RST});
    chk("restore ack", ack_cyc > rst_cyc, 1'b1);
    rds(0, n);
    chk("setups gone", n, 0);
    complete_run();
  end
  initial begin
    #2000000;
    err_count++;
    complete_run();
  end
endmodule
bind image_setting_command_handler image_cmd_chk #(.SETTINGS_PER_SOURCE(SETTINGS_PER_SOURCE))
  image_cmd_chk_i (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .analog_input_i(analog_input_i),
  .settings_o(settings_o), .decode_space_o(decode_space_o),
  .defaults_restored_o(defaults_restored_o), .baud_reset_o(baud_reset_o), .reply_o(reply_o));
